/* design/clk_gate_pkg.sv */
// Constants, types and helpers for the sleep-mode clock gating block.
// Functional notes
// [R1] Each implemented bit clocks or disables one unit
// [R2] Access to an unclocked unit raises bus fault
// [R3] Reset clears every bit, all units off
// [R4] Timers 3..0 enables at bits 19..16
// [R5] Two-wire 1 bit 14, two-wire 0 bit 12
// [R6] Sync serial 1 bit 5, 0 bit 4
// [R7] Async serial 2, 1, 0 at bits 2..0
// [R8] All other bits read-only, read zero
// [R9] Software preserves reserved bits on read-modify-write
// [R10] Register applies during sleep operation only
// [R11] Sleep register used only with auto gating set
// [R12] Decoded at offset 0x114 from system base
// [R13] Software enables units it needs in sleep
// [R14] Gated clocks switch without runt pulses
package clk_gate_pkg;

  // ---------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------
  localparam logic [31:0] SYS_CTRL_BASE = 32'h400f_e000;
  localparam logic [31:0] SLEEP_GATE_OFFSET = 32'h0000_0114;
  localparam logic [31:0] GATE_STATUS_OFFSET = 32'h0000_01f0;
  localparam logic [31:0] SLEEP_GATE_RESET = 32'h0000_0000;
  // Writable enables; everything else is reserved and reads zero.
  localparam logic [31:0] SLEEP_GATE_MASK = 32'h000f_5037;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Units and their enable bit positions
  // ---------------------------------------------------------------
  localparam int NUM_UNITS = 11;
  localparam int UNIT_SEL_W = 4;
  // Order: async serial 0..2, sync serial 0..1, two-wire 0..1,
  // general-purpose counters 0..3.
  localparam int UNIT_BIT [NUM_UNITS] =
    '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 19};

  typedef enum logic [1:0] {mode_run, mode_sleep, mode_deep} mode_type;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [NUM_UNITS-1:0] unit_enables(
    input logic [31:0] r
  );
    logic [NUM_UNITS-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      v[i] = r[UNIT_BIT[i]];
    end
    return v;
  endfunction

  function automatic logic reg_hit(
    input logic [31:0] addr,
    input logic [31:0] offset
  );
    return addr == (SYS_CTRL_BASE + offset);
  endfunction

endpackage

/* design/unit_gate_if.sv */
// Interface carrying unit enables and gated clocks between modules.
`timescale 1ns/100ps
interface unit_gate_if #(parameter int N = 11);
  logic [N-1:0] en;
  logic [N-1:0] gclk;
  modport ctl (output en, input gclk);
  modport cells (input en, output gclk);
  modport chk (input en);
endinterface

/* design/unit_clock_cells.sv */
// Glitch-free clock gate cells, one per unit.
`timescale 1ns/100ps
module unit_clock_cells #(
  parameter int N = 11
) (
  // Clock
  input wire logic clk,
  // Enables in, gated clocks out
  unit_gate_if.cells gate
);

  // ---------------------------------------------------------------
  // Gate cells
  // ---------------------------------------------------------------
  // The enable is latched while clk is low, so a change can only take
  // effect at the next rising edge and never chops a high phase.
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_cell
      logic en_lat;
      always_latch
      begin
        if (!clk)
          en_lat = gate.en[i]; // R14
      end
      assign gate.gclk[i] = clk & en_lat; // R1
    end
  endgenerate

endmodule

/* design/unit_fault_check.sv */
// Bus fault detection for accesses to unclocked units.
`timescale 1ns/100ps
module unit_fault_check
  import clk_gate_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Peripheral access
  input wire logic periph_access,
  input wire logic [UNIT_SEL_W-1:0] periph_unit,
  unit_gate_if.chk gate,
  // Fault answer
  output logic bus_fault
);

  logic fault_q;
  logic fault_d;
  logic unit_on;

  // ---------------------------------------------------------------
  // Fault decision
  // ---------------------------------------------------------------
  always_comb
  begin
    unit_on = 1'b0;
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      if (periph_unit == UNIT_SEL_W'(i))
        unit_on = gate.en[i];
    end
    // Unknown unit numbers fault as well, like an unclocked unit.
    fault_d = periph_access & ~unit_on; // R2
    if (!clk_en)
      fault_d = fault_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fault_q <= 1'b0;
    else
      fault_q <= fault_d;
  end

  assign bus_fault = fault_q;

endmodule

/* design/sleep_clock_gating.sv */
// Sleep-mode clock gating register, mode selection and unit clocks.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module sleep_clock_gating
  import clk_gate_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  // Operating mode and companion gating
  input wire logic sleep_active,
  input wire logic deep_sleep_active,
  input wire logic auto_clock_gating,
  input wire logic [31:0] run_clock_gate_ctrl_1,
  input wire logic [31:0] deep_sleep_clock_gate_ctrl_1,
  // Peripheral accesses
  input wire logic periph_access,
  input wire logic [UNIT_SEL_W-1:0] periph_unit,
  output logic bus_fault,
  // Units
  output logic [NUM_UNITS-1:0] unit_enable,
  output logic [NUM_UNITS-1:0] unit_clk
);

  logic [31:0] sleep_clock_gate_ctrl_1_q;
  logic [31:0] sleep_clock_gate_ctrl_1_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [NUM_UNITS-1:0] eff_q;
  logic [NUM_UNITS-1:0] eff_d;
  mode_type mode_q;
  mode_type mode_d;

  unit_gate_if #(.N(NUM_UNITS)) gate ();

  // ---------------------------------------------------------------
  // Register write
  // ---------------------------------------------------------------
  always_comb
  begin
    sleep_clock_gate_ctrl_1_d = sleep_clock_gate_ctrl_1_q;
    if (clk_en && wr_stb && reg_hit(addr, SLEEP_GATE_OFFSET)) // R12
      // Reserved bits never store, so they always read back zero.
      sleep_clock_gate_ctrl_1_d = wdata & SLEEP_GATE_MASK; // R4 R5 R6 R7 R8
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sleep_clock_gate_ctrl_1_q <= SLEEP_GATE_RESET; // R3
    else
      sleep_clock_gate_ctrl_1_q <= sleep_clock_gate_ctrl_1_d;
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  // Read data stand in the cycle after the strobe and are held while clk_en
  // is low; unmapped addresses answer zero.
  always_comb
  begin
    rdata_d = READ_IDLE;
    if (rd_stb)
    begin
      if (reg_hit(addr, SLEEP_GATE_OFFSET))
        rdata_d = sleep_clock_gate_ctrl_1_q & SLEEP_GATE_MASK; // R8
      else if (reg_hit(addr, GATE_STATUS_OFFSET))
        rdata_d = {{(32-NUM_UNITS){1'b0}}, eff_q};
    end
    if (!clk_en)
      rdata_d = rdata_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= READ_IDLE;
    else
      rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;

  // ---------------------------------------------------------------
  // Mode selection and effective enables
  // ---------------------------------------------------------------
  // Without auto gating the run-mode enables stay in force in every
  // mode, so sleep entry never silently stops a unit.
  always_comb
  begin
    mode_d = mode_run;
    if (auto_clock_gating) // R11
    begin
      if (deep_sleep_active)
        mode_d = mode_deep;
      else if (sleep_active)
        mode_d = mode_sleep; // R10
    end
    if (!clk_en)
      mode_d = mode_q;
  end

  always_comb
  begin
    case (mode_d)
      mode_sleep: eff_d = unit_enables(sleep_clock_gate_ctrl_1_d); // R1 R10
      mode_deep: eff_d = unit_enables(deep_sleep_clock_gate_ctrl_1);
      mode_run: eff_d = unit_enables(run_clock_gate_ctrl_1);
      default: eff_d = '0;
    endcase
    if (!clk_en)
      eff_d = eff_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= mode_run;
      eff_q <= '0; // R3
    end
    else
    begin
      mode_q <= mode_d;
      eff_q <= eff_d;
    end
  end

  // ---------------------------------------------------------------
  // Unit clocks and fault check
  // ---------------------------------------------------------------
  assign gate.en = eff_q;
  assign unit_enable = eff_q;
  assign unit_clk = gate.gclk;

  unit_clock_cells #(.N(NUM_UNITS)) cells (
    .clk(clk),
    .gate(gate.cells)
  );

  unit_fault_check fault (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .periph_access(periph_access),
    .periph_unit(periph_unit),
    .gate(gate.chk),
    .bus_fault(bus_fault)
  );

endmodule

/* tb/sleep_gate_assertions.sv */
// Port-level assertions for the sleep-mode clock gating block.
`timescale 1ns/100ps
module sleep_gate_checker
  import clk_gate_pkg::*;
(
  // Watched ports
  input wire logic clk, nrst, clk_en, wr_stb, rd_stb, periph_access,
  input wire logic sleep_active, deep_sleep_active, auto_clock_gating,
  input wire logic [31:0] addr, wdata, rdata, run_clock_gate_ctrl_1,
  input wire logic [31:0] deep_sleep_clock_gate_ctrl_1,
  input wire logic [UNIT_SEL_W-1:0] periph_unit,
  input wire logic bus_fault,
  input wire logic [NUM_UNITS-1:0] unit_enable, unit_clk
);
  function automatic logic [10:0] f(logic [31:0] x);
    return {x[19:16], x[14], x[12], x[5:4], x[2:0]};
  endfunction
  wire hit = addr == SYS_CTRL_BASE + SLEEP_GATE_OFFSET;
  wire st = addr == SYS_CTRL_BASE + GATE_STATUS_OFFSET;
  wire slp = auto_clock_gating && sleep_active && !deep_sleep_active;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  AST_RESET: assert property ($rose(nrst) |-> !bus_fault && rdata == 0
    && unit_enable == 0) else $error("outputs not clear after reset");
  AST_RD_IDLE: assert property (clk_en && !(rd_stb && (hit || st))
    |=> rdata == 0) else $error("read data outside a mapped read");
  AST_RSV: assert property (clk_en && rd_stb && hit
    |=> (rdata & 32'hfff0_afc8) == 0) else $error("reserved bit set");
  AST_RD_BACK: assert property (clk_en && wr_stb && hit ##1
    clk_en && rd_stb && hit |=> rdata == ($past(wdata, 2) & 32'h000f_5037))
    else $error("read back differs from write");
  AST_WR_SLEEP: assert property (clk_en && wr_stb && hit && slp
    |=> unit_enable == f($past(wdata))) else $error("sleep enables wrong");
  AST_RUN: assert property (clk_en && !(auto_clock_gating &&
    (sleep_active || deep_sleep_active)) |=> unit_enable ==
    f($past(run_clock_gate_ctrl_1))) else $error("run enables wrong");
  AST_DEEP: assert property (clk_en && auto_clock_gating &&
    deep_sleep_active |=> unit_enable ==
    f($past(deep_sleep_clock_gate_ctrl_1))) else $error("deep enables wrong");
  AST_FAULT: assert property (clk_en && periph_access |=> bus_fault ==
    ($past(periph_unit) > 10 || !$past(unit_enable[periph_unit])))
    else $error("fault answer wrong");
  // At each falling edge the high phase must match the enable held before.
  AST_GATED: assert property (@(negedge clk)
    unit_clk == $past(unit_enable)) else $error("gated clock wrong");
  cover property (bus_fault);
  cover property (wr_stb && hit ##1 rd_stb && hit);
  cover property (auto_clock_gating && deep_sleep_active);
endmodule
bind sleep_clock_gating sleep_gate_checker i_sleep_gate_checker (.*);

/* tb/cpu_access_model.sv */
// Processor-side model issuing one-cycle accesses to peripheral units.
`timescale 1ns/100ps
module cpu_access_model
  import clk_gate_pkg::*;
(
  // Clock and access
  input wire logic clk,
  output logic periph_access = 0,
  output logic [UNIT_SEL_W-1:0] periph_unit = 0
);
  // The index is inverted once released, so nothing leans on a stale value.
  task automatic access(input logic [UNIT_SEL_W-1:0] u);
    @(posedge clk);
    periph_access <= 1;
    periph_unit <= u;
    @(posedge clk);
    periph_access <= 0;
    periph_unit <= ~u;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the sleep-mode clock gating block.
`timescale 1ns/100ps
module testbench;
  import clk_gate_pkg::*;
  localparam logic [31:0] A = 32'h400f_e114;
  localparam int pos [11] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 19};
  localparam logic [2:0] md [4] = '{3'b110, 3'b100, 3'b111, 3'b010};
  localparam logic [10:0] me [4] = '{11'h400, 11'h001, 11'h040, 11'h001};
  logic clk = 0, nrst = 0, clk_en = 1, wr_stb = 0, rd_stb = 0, v = 0;
  logic auto_clock_gating = 1, sleep_active = 1, deep_sleep_active = 0;
  logic periph_access, bus_fault;
  logic [31:0] addr = 0, wdata = 0, rdata, ex = 0, ev = 0;
  logic [31:0] run_clock_gate_ctrl_1 = 32'h1;
  logic [31:0] deep_sleep_clock_gate_ctrl_1 = 32'h4000;
  logic [3:0] periph_unit;
  logic [10:0] unit_enable, unit_clk;
  int err_total = 0, n_compared = 0;
  sleep_clock_gating i_sleep_clock_gating (.*);
  cpu_access_model i_cpu_access_model (.*);
  task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h, expected %h", $time, s, e);
    end
  endtask
  // Read data are checked a cycle later, so bus cycles may run back to back.
  task automatic op(input logic w, r, input logic [31:0] a, d, e);
    @(posedge clk);
    wr_stb <= w;
    rd_stb <= r;
    addr <= a;
    wdata <= d;
    ex <= e;
  endtask
  task automatic flt(input logic [3:0] u, input logic e);
    i_cpu_access_model.access(u);
    @(negedge clk) chk(32'(bus_fault), 32'(e));
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial forever #10 clk = ~clk;
  always @(posedge clk) {v, ev} <= {rd_stb, ex};
  always @(negedge clk) if (v) chk(rdata, ev);
  initial
  begin
    #200us;
    err_total++;
    complete_run;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1;
    op(0, 1, A, 0, 0);
    op(0, 0, 0, 0, 0);
    @(negedge clk) chk(32'(unit_enable), 0);
    op(1, 0, A, '1, 0);
    op(0, 1, A, 0, 32'h000f_5037);
    op(0, 0, 0, 0, 0);
    @(negedge clk) chk(32'(unit_enable), 32'h7ff);
    $display("test done: reset and map");
    for (int i = 0; i < 11; i++)
    begin
      op(1, 0, A, 32'h1 << pos[i], 0);
      op(0, 1, A, 0, 32'h1 << pos[i]);
      op(0, 0, 0, 0, 0);
      @(negedge clk) chk(32'(unit_enable), 32'h1 << i);
      flt(4'(i), 0);
      flt(4'((i + 1) % 11), 1);
    end
    flt(4'hb, 1);
    $display("test done: units and faults");
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk);
      {auto_clock_gating, sleep_active, deep_sleep_active} <= md[m];
      repeat (2) @(negedge clk);
      chk(32'(unit_enable), 32'(me[m]));
    end
    $display("test done: modes");
    op(0, 1, 32'h400f_e1f0, 0, 32'h1);
    op(1, 0, A + 4, '1, 0);
    op(0, 1, A + 4, 0, 0);
    op(0, 0, 0, 0, 0);
    clk_en <= 0;
    op(1, 0, A, 0, 0);
    op(0, 0, 0, 0, 0);
    clk_en <= 1;
    op(0, 1, A, 0, 32'h0008_0000);
    op(1, 0, A, 32'h0008_0000 | 32'h11, 0);
    op(0, 1, A, 0, 32'h0008_0011);
    op(0, 0, 0, 0, 0);
    repeat (2) @(negedge clk);
    $display("test done: access rules");
    complete_run;
  end
endmodule
